// ===== shared/fir_pkg.sv
// Shared constants for the two-path, shared-coefficient FIR link.
// Assumes both ends import this package; the output FIFO takes its sizes as parameters.
package fir_pkg;
    localparam int NPATH     = 2;   // Parallel datapaths
    localparam int NCH       = 3;   // Interleaved channels per path
    localparam int CH_W      = 2;   // Channel identifier width
    localparam int DW        = 16;  // Sample width per path
    localparam int NTAP      = 16;  // Taps actually computed
    localparam int SPEC_TAPS = 14;  // Taps specified by the user
    localparam int COEF_W    = 16;  // Reload word width
    localparam int CFIELD_W  = 18;  // Stored coefficient field width
    localparam int ACC_W     = 38;  // 34-bit product plus 4 growth bits
    localparam int K_W       = 4;   // Reload counter width
    localparam int FIFO_W    = NPATH * ACC_W + CH_W;
    localparam int FIFO_D    = 8;
    localparam logic [K_W-1:0] K_LAST = 4'hF;

    // Storage location of reload word k: blocks of four taken from the
    // top of the response downward (12..15, 8..11, 4..7, 0..3)
    function automatic logic [K_W-1:0] reload_coef_idx(
        input logic [K_W-1:0] k);
        reload_coef_idx = {~k[3:2], k[1:0]};
    endfunction
endpackage

// ===== shared/fir_link_if.sv
// Link between the stream source / reload logic and the filter.
// Assumes both ends share one clock supplied outside the interface.
`timescale 1ns/100ps
interface fir_link_if;
    import fir_pkg::*;
    logic                      d_valid;
    logic                      d_ready;
    logic [NPATH*DW-1:0]       d_data;
    logic [CH_W-1:0]           d_chan;
    logic                      r_valid;
    logic                      r_ready;
    logic [NPATH*ACC_W-1:0]    r_data;
    logic [CH_W-1:0]           r_chan;
    logic                      c_valid;
    logic                      c_ready;
    logic [COEF_W-1:0]         c_data;

    modport filter (input d_valid, d_data, d_chan, r_ready, c_valid,
                    c_data,
                    output d_ready, r_valid, r_data, r_chan, c_ready);
    modport source (output d_valid, d_data, d_chan, r_ready, c_valid,
                    c_data,
                    input d_ready, r_valid, r_data, r_chan, c_ready);
endinterface

// ===== rtl/fir_filter.sv
// Two-path FIR filter with shared control, shared coefficient bank,
// interleaved channels and run-time coefficient reload.
// Assumes one clock, and a source that delivers reload words in order.
`timescale 1ns/100ps

// Output FIFO: width and depth shape the storage
module fir_out_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic        push;
    logic        pop;

    // Full and empty straight from the occupancy count
    assign o_in_ready  = (st_reg.cnt != (AW+1)'(D));
    assign o_out_valid = (st_reg.cnt != '0);
    assign o_out_data  = st_reg.mem[st_reg.rp];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Pointer and count update
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = i_in_data;
            st_next.wp = (st_reg.wp == AW'(D-1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == AW'(D-1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

module fir_filter
    import fir_pkg::*;
(
    input  wire logic           i_clk,
    input  wire logic           i_rst_n,
    fir_link_if.filter          lk,
    output logic                o_reload_done,
    output logic [K_W-1:0]      o_reload_count
);
    typedef struct packed {
        logic [NCH-1:0][NPATH-1:0][NTAP-1:0][DW-1:0] hist;
        logic [NTAP-1:0][CFIELD_W-1:0]               coef_act;
        logic [NTAP-1:0][CFIELD_W-1:0]               coef_shd;
        logic [K_W-1:0]                              rld_cnt;
        logic                                        done;
        logic                                        out_valid;
        logic [NPATH*ACC_W-1:0]                      out_data;
        logic [CH_W-1:0]                             out_ch;
    } filt_state_t;

    filt_state_t st_reg;
    filt_state_t st_next;
    logic        fifo_in_ready;
    logic        take;
    logic [FIFO_W-1:0] fifo_out;

    // A sample is taken only when the result stage can move on, so
    // a full FIFO stalls the source rather than dropping results
    assign lk.d_ready     = !st_reg.out_valid || fifo_in_ready;
    assign take           = lk.d_valid && lk.d_ready;
    assign lk.c_ready     = 1'b1;   // Reload words never stall
    assign o_reload_done  = st_reg.done;
    assign o_reload_count = st_reg.rld_cnt;

    // Filtering and reload bookkeeping
    always_comb begin
        logic [NTAP-1:0][DW-1:0]  line;
        logic signed [ACC_W-1:0]  acc;
        logic [K_W-1:0]           loc;
        line    = '0;
        acc     = '0;
        loc     = '0;
        st_next = st_reg;
        st_next.done = 1'b0;
        if (st_reg.out_valid && fifo_in_ready) begin
            st_next.out_valid = 1'b0;
        end
        // Channel id picks the history; ids of NCH and above are accepted
        // and dropped so a bad id cannot index past the memory
        if (take && (lk.d_chan < CH_W'(NCH))) begin
            for (int p = 0; p < NPATH; p++) begin
                line = st_reg.hist[lk.d_chan][p];
                line = {line[NTAP-2:0], lk.d_data[p*DW +: DW]};
                st_next.hist[lk.d_chan][p] = line;
                acc = '0;
                for (int t = 0; t < NTAP; t++) begin
                    acc = acc + ACC_W'($signed(line[t])
                                * $signed(st_reg.coef_act[t]));
                end
                st_next.out_data[p*ACC_W +: ACC_W] = acc;
            end
            st_next.out_ch    = lk.d_chan;
            st_next.out_valid = 1'b1;
        end
        // The reload port stays at coefficient width because no pair
        // technique is built here
        // Reload into the shadow bank; the counter places each word
        if (lk.c_valid) begin
            loc = reload_coef_idx(st_reg.rld_cnt);
            st_next.coef_shd[loc] = {{(CFIELD_W-COEF_W){
                lk.c_data[COEF_W-1]}}, lk.c_data};
            if (st_reg.rld_cnt == K_LAST) begin
                st_next.rld_cnt  = '0;
                st_next.coef_act = st_next.coef_shd;
                st_next.done     = 1'b1;
            end else begin
                st_next.rld_cnt = st_reg.rld_cnt + 1'b1;
            end
        end
    end

    // One register set holds all state but the output FIFO's: control is not per path
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Results queue toward the receiver
    fir_out_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (st_reg.out_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   ({st_reg.out_ch, st_reg.out_data}),
        .o_out_valid (lk.r_valid),
        .i_out_ready (lk.r_ready),
        .o_out_data  (fifo_out)
    );
    assign lk.r_data = fifo_out[NPATH*ACC_W-1:0];
    assign lk.r_chan = fifo_out[FIFO_W-1 -: CH_W];
endmodule

// ===== rtl/fir_source.sv
// Upstream end: streams samples with a shared channel id and sends
// coefficients in reload order with zero padding.
// Assumes the same clock as the filter; user holds natural-order taps.
`timescale 1ns/100ps
module fir_source
    import fir_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    fir_link_if.source                  lk,
    input  wire logic                   i_smp_valid,
    output logic                        o_smp_ready,
    input  wire logic [NPATH*DW-1:0]    i_smp_data,
    output logic                        o_res_valid,
    input  wire logic                   i_res_ready,
    output logic [NPATH*ACC_W-1:0]      o_res_data,
    output logic [CH_W-1:0]             o_res_chan,
    input  wire logic                   i_cwr,
    input  wire logic [K_W-1:0]         i_cwr_idx,
    input  wire logic [COEF_W-1:0]      i_cwr_data,
    input  wire logic                   i_reload_start,
    output logic                        o_reload_busy
);
    typedef struct packed {
        logic [NTAP-1:0][COEF_W-1:0] tab;
        logic [CH_W-1:0]             ch;
        logic                        busy;
        logic [K_W-1:0]              k;
        logic [COEF_W-1:0]           word;
    } src_state_t;

    src_state_t st_reg;
    src_state_t st_next;

    // Sample path passes straight through, channel id from a counter
    assign lk.d_valid    = i_smp_valid;
    assign lk.d_data     = i_smp_data;
    assign lk.d_chan     = st_reg.ch;
    assign o_smp_ready   = lk.d_ready;
    assign o_res_valid   = lk.r_valid;
    assign lk.r_ready    = i_res_ready;
    assign o_res_data    = lk.r_data;
    assign o_res_chan    = lk.r_chan;
    assign lk.c_valid    = st_reg.busy;
    assign lk.c_data     = st_reg.word;
    assign o_reload_busy = st_reg.busy;

    // Reload word k carries the tap that the filter stores at k's slot;
    // taps past the specified count are the zeros appended at the end
    function automatic logic [COEF_W-1:0] word_for(
        input logic [NTAP-1:0][COEF_W-1:0] tab,
        input logic [K_W-1:0]              k);
        logic [K_W-1:0] idx;
        // Non-symmetric build, one slice per MAC: no leading pad
        // no pair sums or differences
        // and no bit-slice words
        idx = reload_coef_idx(k);
        word_for = ({1'b0, idx} >= (K_W+1)'(SPEC_TAPS))
                   ? '0 : tab[idx];
    endfunction

    // Channel rotation, table writes and reload sequencing
    always_comb begin
        st_next = st_reg;
        if (lk.d_valid && lk.d_ready) begin
            st_next.ch = (st_reg.ch == CH_W'(NCH-1)) ? '0
                         : st_reg.ch + 1'b1;
        end
        // Writes during a reload are ignored to keep the set coherent
        if (i_cwr && !st_reg.busy) begin
            st_next.tab[i_cwr_idx] = i_cwr_data;
        end
        if (!st_reg.busy && i_reload_start) begin
            st_next.busy = 1'b1;
            st_next.k    = '0;
            st_next.word = word_for(st_reg.tab, '0);
        end else if (st_reg.busy && lk.c_ready) begin
            if (st_reg.k == K_LAST) begin
                st_next.busy = 1'b0;
            end else begin
                st_next.k    = st_reg.k + 1'b1;
                st_next.word = word_for(st_reg.tab, st_reg.k + 1'b1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// ===== bench/fir_link_chk.sv
// Link checker: reload counting, done pulse, sample and result stream.
// Assumes the test top wires it to the link interface signals.
`timescale 1ns/100ps
module fir_link_chk
    import fir_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   d_valid,
    input  wire logic                   d_ready,
    input  wire logic [CH_W-1:0]        d_chan,
    input  wire logic                   r_valid,
    input  wire logic                   r_ready,
    input  wire logic [NPATH*ACC_W-1:0] r_data,
    input  wire logic [CH_W-1:0]        r_chan,
    input  wire logic                   c_valid,
    input  wire logic                   c_ready,
    input  wire logic                   o_reload_done,
    input  wire logic [K_W-1:0]         o_reload_count
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // Reload side: every word is taken and counted
    chk_reload_ready_high: assert property (c_ready)
        else $error("reload ready low");
    chk_count_step: assert property (c_valid |=>
        o_reload_count == $past(o_reload_count) + 4'h1)
        else $error("reload count did not step");
    chk_count_hold: assert property (!c_valid |=>
        $stable(o_reload_count)) else $error("reload count moved");
    chk_words_burst: assert property ($rose(c_valid) |->
        c_valid [*8]) else $error("reload burst broken");
    // The swap is signalled only by the last word of a sequence
    chk_done_on_last: assert property (
        c_valid && o_reload_count == K_LAST |=> o_reload_done)
        else $error("done missing after last word");
    chk_done_cause: assert property (o_reload_done |->
        $past(c_valid) && $past(o_reload_count) == K_LAST)
        else $error("done without last word");
    chk_done_single: assert property (o_reload_done |=>
        !o_reload_done) else $error("done longer than a cycle");

    // Sample side: shared channel id turns 0,1,2 per take
    chk_chan_cycle: assert property (d_valid && d_ready |=>
        d_chan == (($past(d_chan) == 2'h2) ? 2'h0 : $past(d_chan) + 2'h1))
        else $error("channel sequence broken");
    chk_result_latency: assert property (
        d_valid && d_ready |-> ##[1:2] r_valid)
        else $error("result late");
    chk_result_hold: assert property (r_valid && !r_ready |=>
        r_valid && $stable(r_data) && $stable(r_chan))
        else $error("result changed while stalled");
    chk_refuse_full: assert property (!d_ready |-> r_valid)
        else $error("sample refused with empty output");

    cover property (o_reload_done);
    cover property (!d_ready);
    cover property (r_valid && !r_ready);
    cover property (d_valid && d_ready && d_chan == 2'h2);
endmodule

// ===== bench/fir_parallel_path_coef_reload_test.sv
// Test top: source and filter joined by the link, checked end to end.
// Assumes one clock; a reference model predicts every result word.
`timescale 1ns/100ps
module fir_parallel_path_coef_reload_test;
    import fir_pkg::*;
    logic                     i_clk = 1'b0;
    logic                     i_rst_n = 1'b0;
    logic                     smp_valid = 1'b0;
    logic                     res_ready = 1'b1;
    logic                     cwr = 1'b0;
    logic                     start = 1'b0;
    logic [K_W-1:0]           cwr_idx = '0;
    logic [COEF_W-1:0]        cwr_data = '0;
    logic [NPATH*DW-1:0]      smp_data = '0;
    logic                     smp_ready, res_valid, busy, done;
    logic [NPATH*ACC_W-1:0]   res_data;
    logic [CH_W-1:0]          res_chan, ch = '0;
    logic [K_W-1:0]           count;
    logic signed [COEF_W-1:0] tab [NTAP];
    logic signed [COEF_W-1:0] cm [NTAP] = '{default: '0};
    logic signed [DW-1:0]     hx [NCH][NPATH][NTAP] = '{default: '0};
    logic [FIFO_W-1:0]        expq [$];
    int                       err_count = 0;
    int                       total_checks = 0;
    int                       g = 0;
    int                       rk = 0;

    fir_link_if lk ();
    fir_filter i_fir_filter (.i_clk(i_clk), .i_rst_n(i_rst_n), .lk(lk),
        .o_reload_done(done), .o_reload_count(count));
    fir_source i_fir_source (.i_clk(i_clk), .i_rst_n(i_rst_n), .lk(lk),
        .i_smp_valid(smp_valid), .o_smp_ready(smp_ready),
        .i_smp_data(smp_data), .o_res_valid(res_valid),
        .i_res_ready(res_ready), .o_res_data(res_data),
        .o_res_chan(res_chan), .i_cwr(cwr), .i_cwr_idx(cwr_idx),
        .i_cwr_data(cwr_data), .i_reload_start(start),
        .o_reload_busy(busy));
    fir_link_chk i_fir_link_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .d_valid(lk.d_valid), .d_ready(lk.d_ready), .d_chan(lk.d_chan),
        .r_valid(lk.r_valid), .r_ready(lk.r_ready), .r_data(lk.r_data),
        .r_chan(lk.r_chan), .c_valid(lk.c_valid), .c_ready(lk.c_ready),
        .o_reload_done(done), .o_reload_count(count));

    // 25 MHz clock
    always #20 i_clk = ~i_clk;

    task automatic check(input logic [FIFO_W-1:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // A used-up wait bound counts as a mismatch and ends the run
    task automatic guard(input int lim);
        if (g >= lim) begin
            err_count++;
            summarize();
        end
        g = 0;
    endtask

    // Reference model; paths share one active set, so both see the same
    always @(posedge i_clk) begin
        logic signed [ACC_W-1:0] acc;
        logic [FIFO_W-1:0]       ev;
        logic [COEF_W-1:0]       cw;
        int                      ci;
        // Word k must carry the tap of block (last - k/4), zero if padded
        if (lk.c_valid && lk.c_ready) begin
            ci = (NTAP / 4 - 1 - rk / 4) * 4 + rk % 4;
            cw = (ci < SPEC_TAPS) ? tab[ci] : '0;
            check(FIFO_W'(lk.c_data), FIFO_W'(cw));
            rk = (rk + 1) % NTAP;
        end
        if (done) begin
            for (int t = 0; t < NTAP; t++)
                cm[t] = (t < SPEC_TAPS) ? tab[t] : 16'sh0;
        end
        if (smp_valid && smp_ready) begin
            check(FIFO_W'(lk.d_chan), FIFO_W'(ch));
            ev[FIFO_W-1 -: CH_W] = ch;
            for (int p = 0; p < NPATH; p++) begin
                for (int t = NTAP - 1; t > 0; t--)
                    hx[ch][p][t] = hx[ch][p][t-1];
                hx[ch][p][0] = smp_data[p*DW +: DW];
                acc = '0;
                for (int t = 0; t < NTAP; t++)
                    acc += ACC_W'(cm[t]) * ACC_W'(hx[ch][p][t]);
                ev[p*ACC_W +: ACC_W] = acc;
            end
            expq.push_back(ev);
            ch = (ch == CH_W'(NCH - 1)) ? '0 : ch + 1'b1;
        end
        if (res_valid && res_ready) begin
            if (expq.size() == 0)
                check('1, '0);
            else
                check({res_chan, res_data}, expq.pop_front());
        end
    end

    // Send n samples, optionally throttle results, then drain
    task automatic stream(input int n, input logic stall);
        int k = 0;
        smp_data <= {DW'(k * 16'h0923), DW'(16'h7100 - k * 16'h0541)};
        smp_valid <= (n > 0);
        while (k < n && g < 500) begin
            @(posedge i_clk);
            g++;
            res_ready <= !stall || g[1];
            if (smp_ready) begin
                k++;
                smp_data <= {DW'(k * 16'h0923), DW'(16'h7100 - k * 16'h0541)};
                if (k == n)
                    smp_valid <= 1'b0;
            end
        end
        while (expq.size() != 0 && g < 600) begin
            @(posedge i_clk);
            g++;
            res_ready <= 1'b1;
        end
        // A sample loop that ran out leaves k short: count it as a hang
        if (k < n)
            g = 600;
        guard(600);
    endtask

    // Write the table in natural order; taps 14 and 15 must be padded
    task automatic load(input int s);
        for (int t = 0; t < NTAP; t++) begin
            tab[t] = COEF_W'(s * (t[0] ? -(t * 499 + 1) : t * 263 + 9));
            cwr <= 1'b1;
            cwr_idx <= K_W'(t);
            cwr_data <= tab[t];
            @(posedge i_clk);
        end
        cwr <= 1'b0;
        start <= 1'b1;
        // Samples keep flowing so the swap edge itself is exercised
        smp_valid <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        while (!done && g < 40) begin
            @(posedge i_clk);
            g++;
            check(FIFO_W'(busy), FIFO_W'(!done));
        end
        smp_valid <= 1'b0;
        guard(40);
        check(FIFO_W'(count), '0);
    endtask

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        check(FIFO_W'({done, count}), '0);
        stream(6, 1'b0);
        $display("test reset set done");
        load(1);
        stream(48, 1'b1);
        $display("test first reload done");
        res_ready <= 1'b0;
        smp_valid <= 1'b1;
        while (smp_ready && g < 40) begin
            @(posedge i_clk);
            g++;
        end
        guard(40);
        check(FIFO_W'(expq.size()), FIFO_W'(FIFO_D + 1));
        stream(0, 1'b0);
        $display("test fill and drain done");
        load(2);
        stream(30, 1'b1);
        $display("test second reload done");
        summarize();
    end
endmodule
